// >>> hw/pemx_pin_assign.sv
/*
 * pemx_pin_assign: port E bus control pin assignment, pull-up and drive registers.
 * assumes mode and e_stretch_bit come from the mode register, func from the bus
 * sequencer, and a byte register port with read data one cycle after the strobe.
 */
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// How it works
// - normal single chip: all port E general
// - normal expanded: only data enable, E clock
// - special expanded: bus set plus pipe status
// - special single chip adds calibration reference
// - peripheral: assignment hidden, clock test set
// - protected bits: once normal, skip-first special
// - clock test bit: never normal, skip-first special
// - E clock disable per-mode writes; E direction
// - calibration on pin 7 when allowed
// - pin 7 data enable or inverted E
// - single chip ignores pin 7 data enable and invert bits
// - clock test on pin 6, pipe overrides
// - pipe status on pins 6 and 5
// - pin 4 E clock, stretch gates single chip
// - pin 3 low strobe unless excluded modes
// - low byte tag sampled at E fall
// - pin 2 read/write outside single chip
// - pull-up bits per port, E resets one
// - port E pull-ups on pins 7,3..0
// - reduced drive bit per port
// - pull-up register unmapped in peripheral
// - alternate function overrides direction bit
module pemx_pin_assign
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // operating mode
    input wire pemx_pkg::pemx_mode_type mode,
    input wire logic e_stretch_bit,
    input wire logic debugTagOn,
    // register port
    input wire pemx_pkg::pemx_bus_type bus,
    output logic [7:0] rdata,
    // bus sequencer functions and general I/O
    input wire pemx_pkg::pemx_func_type func,
    input wire logic [7:0] port_e_direction,
    input wire logic [7:0] gpioOut,
    input wire logic [7:0] pinIn,
    // pins
    output logic [7:0] pinOut,
    output logic [7:0] pinOe,
    output logic [7:0] pinPullup,
    output logic [7:0] pullup_control,
    output logic [7:0] reduced_drive_control,
    output logic low_byte_tag_in
);
    typedef struct packed
    {
        logic [7:0] assign_;
        logic [7:0] pull;
        logic [7:0] drive;
        logic [7:0] rdata;
        logic [7:0] pinOut;
        logic [7:0] pinOe;
        logic [7:0] pinPullup;
        logic tag;
    } pemx_state_type;

    pemx_state_type state;
    pemx_state_type next_state;
    logic singleChip, special, expanded, peripheral, normalExp, narrowNorm;
    logic [7:0] allowA, allowD, onceA, anyA;
    logic wrA, wrP, wrD;
    logic [7:0] altSel;
    logic [7:0] altVal;
    logic [7:0] resetAssign;

    pemx_mode_decode u_dec
    (
        .mode(mode),
        .singleChip(singleChip),
        .special(special),
        .expanded(expanded),
        .peripheral(peripheral),
        .normalExp(normalExp),
        .narrowNorm(narrowNorm)
    );

    // assignment and pull-up hidden in peripheral
    assign wrA = bus.write && bus.addr == pemx_pkg::ADDR_ASSIGN && !peripheral;
    assign wrP = bus.write && bus.addr == pemx_pkg::ADDR_PULLUP && !peripheral;
    assign wrD = bus.write && bus.addr == pemx_pkg::ADDR_DRIVE && !peripheral;

    // E clock disable: once in normal single chip, any in special single chip
    always_comb
    begin
        onceA = pemx_pkg::ONCE_MASK;
        anyA = 8'h00;
        anyA[pemx_pkg::BIT_CAL] = 1'b1;
        onceA[pemx_pkg::BIT_ECLK_DIS] = 1'b0;
        // clock test never in normal modes
        onceA[pemx_pkg::BIT_CGTEST] = special;
        if (mode == pemx_pkg::MODE_NORM_SC)
            onceA[pemx_pkg::BIT_ECLK_DIS] = 1'b1;
        if (mode == pemx_pkg::MODE_SPEC_SC)
            anyA[pemx_pkg::BIT_ECLK_DIS] = 1'b1;
    end

    pemx_write_gate #(.WIDTH(8)) u_gateA
    (
        .mclk(mclk),
        .reset(reset),
        .write(wrA),
        .special(special),
        .onceBits(onceA),
        .anyBits(anyA),
        .allow(allowA)
    );

    pemx_write_gate #(.WIDTH(8)) u_gateD
    (
        .mclk(mclk),
        .reset(reset),
        .write(wrD),
        .special(special),
        .onceBits(pemx_pkg::PORT_BITS_MASK),
        .anyBits(8'h00),
        .allow(allowD)
    );

    always_comb
    begin
        case (mode)
            pemx_pkg::MODE_NORM_SC: resetAssign = pemx_pkg::RST_NORM_SC;
            pemx_pkg::MODE_NORM_EXP: resetAssign = pemx_pkg::RST_NORM_EXP;
            pemx_pkg::MODE_NORM_NARROW: resetAssign = pemx_pkg::RST_NORM_EXP;
            pemx_pkg::MODE_SPEC_SC: resetAssign = pemx_pkg::RST_SPEC_SC;
            pemx_pkg::MODE_SPEC_EXP: resetAssign = pemx_pkg::RST_SPEC_EXP;
            pemx_pkg::MODE_PERIPH: resetAssign = pemx_pkg::RST_PERIPH;
            default: resetAssign = pemx_pkg::RST_NORM_SC;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin function selection
    always_comb
    begin
        altSel = 8'h00;
        altVal = 8'h00;
        if (expanded && !state.assign_[pemx_pkg::BIT_DATA_EN_DIS])
        begin
            altSel[pemx_pkg::PIN_DATA_EN] = 1'b1;
            altVal[pemx_pkg::PIN_DATA_EN] = state.assign_[pemx_pkg::BIT_INVE]
                ? !func.eclk : func.dataEnable;
        end
        else if (state.assign_[pemx_pkg::BIT_CAL])
        begin
            altSel[pemx_pkg::PIN_DATA_EN] = 1'b1;
            altVal[pemx_pkg::PIN_DATA_EN] = func.calibRef;
        end
        if (expanded && state.assign_[pemx_pkg::BIT_PIPE])
        begin
            altSel[pemx_pkg::PIN_TEST] = 1'b1;
            altSel[pemx_pkg::PIN_PIPE_LO] = 1'b1;
            altVal[pemx_pkg::PIN_TEST] = func.pipeHi;
            altVal[pemx_pkg::PIN_PIPE_LO] = func.pipeLo;
        end
        // clock test unless single chip or normal expanded
        else if (state.assign_[pemx_pkg::BIT_CGTEST] && !singleChip && !normalExp)
        begin
            altSel[pemx_pkg::PIN_TEST] = 1'b1;
            altVal[pemx_pkg::PIN_TEST] = func.clkgenTest;
        end
        // E clock, stretch bit gates single chip
        if (!state.assign_[pemx_pkg::BIT_ECLK_DIS] && !(singleChip && e_stretch_bit))
        begin
            altSel[pemx_pkg::PIN_ECLK] = 1'b1;
            altVal[pemx_pkg::PIN_ECLK] = func.eclk;
        end
        if (state.assign_[pemx_pkg::BIT_LSTR] && !singleChip && !narrowNorm)
        begin
            altSel[pemx_pkg::PIN_LSTR] = 1'b1;
            altVal[pemx_pkg::PIN_LSTR] = func.lowByteStrobe;
        end
        if (state.assign_[pemx_pkg::BIT_RW] && !singleChip)
        begin
            altSel[pemx_pkg::PIN_RW] = 1'b1;
            altVal[pemx_pkg::PIN_RW] = func.readWrite;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        next_state = state;
        next_state.rdata = 8'h00;
        if (wrA)
            next_state.assign_ = (state.assign_ & ~allowA) | (bus.wdata & allowA);
        // pull-up bits, unused bits stay zero
        if (wrP)
            next_state.pull = bus.wdata & pemx_pkg::PORT_BITS_MASK;
        if (wrD)
            next_state.drive = (state.drive & ~allowD)
                | (bus.wdata & allowD & pemx_pkg::PORT_BITS_MASK);
        if (bus.read && !peripheral)
        begin
            case (bus.addr)
                pemx_pkg::ADDR_ASSIGN: next_state.rdata = state.assign_;
                pemx_pkg::ADDR_PULLUP: next_state.rdata = state.pull;
                pemx_pkg::ADDR_DRIVE: next_state.rdata = state.drive;
                default: next_state.rdata = 8'h00;
            endcase
        end
        // alternate function overrides direction; E input in peripheral
        next_state.pinOe = (altSel | (port_e_direction & ~altSel)) & pemx_pkg::OUT_PINS_MASK;
        if (peripheral)
            next_state.pinOe[pemx_pkg::PIN_ECLK] = 1'b0;
        next_state.pinOut = (altVal & altSel) | (gpioOut & ~altSel);
        next_state.pinPullup = {8{state.pull[pemx_pkg::BIT_PORT_E]}}
            & pemx_pkg::PULLUP_E_PINS & ~next_state.pinOe;
        // tag sample at falling E edge
        if (mode == pemx_pkg::MODE_SPEC_EXP && debugTagOn && func.eclkFall
            && state.assign_[pemx_pkg::BIT_LSTR])
            next_state.tag = !pinIn[pemx_pkg::PIN_LSTR];
        if (reset)
        begin
            next_state = '0;
            next_state.assign_ = resetAssign;
            next_state.pull = pemx_pkg::RST_PULLUP;
            next_state.drive = pemx_pkg::RST_DRIVE;
        end
    end

    always_ff @(posedge mclk)
    begin
        state <= next_state;
    end

    assign rdata = state.rdata;
    assign pinOut = state.pinOut;
    assign pinOe = state.pinOe;
    assign pinPullup = state.pinPullup;
    assign pullup_control = state.pull;
    assign reduced_drive_control = state.drive;
    assign low_byte_tag_in = state.tag;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_firstWrite;
        wrA && !u_gateA.seen;
    endsequence

    a_normal_sc_reset: assert property (@(posedge mclk)
        $fell(reset) && mode == pemx_pkg::MODE_NORM_SC |-> state.assign_ == pemx_pkg::RST_NORM_SC)
        else $error("normal single chip reset value wrong");
    a_spec_exp_reset: assert property (@(posedge mclk)
        $fell(reset) && mode == pemx_pkg::MODE_SPEC_EXP |-> state.assign_ == pemx_pkg::RST_SPEC_EXP)
        else $error("special expanded reset value wrong");
    a_periph_hidden: assert property (@(posedge mclk) disable iff (reset)
        bus.read && peripheral |=> rdata == 8'h00)
        else $error("register visible in peripheral mode");
    a_spec_first_drop: assert property (@(posedge mclk) disable iff (reset)
        s_firstWrite and special
        |=> ((state.assign_ ^ $past(state.assign_)) & ~$past(anyA)) == 8'h00)
        else $error("special first write not ignored");
    a_cgtest_normal: assert property (@(posedge mclk) disable iff (reset)
        !special |=> $stable(state.assign_[pemx_pkg::BIT_CGTEST]))
        else $error("clock test bit changed in normal mode");
    a_pipe_pins: assert property (@(posedge mclk) disable iff (reset)
        expanded && state.assign_[pemx_pkg::BIT_PIPE] |=> pinOe[pemx_pkg::PIN_PIPE_LO])
        else $error("pipe pin not driven");
    a_rw_singlechip: assert property (@(posedge mclk) disable iff (reset)
        singleChip && !port_e_direction[pemx_pkg::PIN_RW] ##1 singleChip |-> !pinOe[pemx_pkg::PIN_RW])
        else $error("read/write driven in single chip");
    a_unused_zero: assert property (@(posedge mclk) disable iff (reset)
        pullup_control[3:2] == 2'b00 && reduced_drive_control[3:2] == 2'b00)
        else $error("unused bits set");
endmodule
`default_nettype wire

// >>> hw/pemx_pkg.sv
/*
 * pemx_pkg: constants and carrier types for the port E bus pin assignment block.
 * assumes a byte-wide register port and one clock domain.
 */
package pemx_pkg;
    // register offsets
    localparam logic [7:0] ADDR_ASSIGN = 8'h0A;
    localparam logic [7:0] ADDR_PULLUP = 8'h0C;
    localparam logic [7:0] ADDR_DRIVE = 8'h0D;
    // assignment register fields
    localparam int BIT_DATA_EN_DIS = 7;
    localparam int BIT_CGTEST = 6;
    localparam int BIT_PIPE = 5;
    localparam int BIT_ECLK_DIS = 4;
    localparam int BIT_LSTR = 3;
    localparam int BIT_RW = 2;
    localparam int BIT_CAL = 1;
    localparam int BIT_INVE = 0;
    // pin numbers on port E
    localparam int PIN_DATA_EN = 7;
    localparam int PIN_TEST = 6;
    localparam int PIN_PIPE_LO = 5;
    localparam int PIN_ECLK = 4;
    localparam int PIN_LSTR = 3;
    localparam int PIN_RW = 2;
    // assignment reset values per mode
    localparam logic [7:0] RST_NORM_EXP = 8'h00;
    localparam logic [7:0] RST_SPEC_EXP = 8'h2C;
    localparam logic [7:0] RST_PERIPH = 8'hD0;
    localparam logic [7:0] RST_NORM_SC = 8'h90;
    localparam logic [7:0] RST_SPEC_SC = 8'h2E;
    // pull-up and drive registers
    localparam logic [7:0] RST_PULLUP = 8'h10;
    localparam logic [7:0] RST_DRIVE = 8'h00;
    localparam logic [7:0] PORT_BITS_MASK = 8'hF3;
    localparam logic [7:0] PULLUP_E_PINS = 8'h8F;
    // pins 1:0 are interrupt inputs and never drive
    localparam logic [7:0] OUT_PINS_MASK = 8'hFC;
    localparam int BIT_PORT_E = 4;
    // bits writable once in normal, after first in special
    localparam logic [7:0] ONCE_MASK = 8'hBD;

    // operating modes, one-hot
    typedef enum logic [5:0]
    {
        MODE_NORM_SC = 6'h01,
        MODE_NORM_EXP = 6'h02,
        MODE_NORM_NARROW = 6'h04,
        MODE_SPEC_SC = 6'h08,
        MODE_SPEC_EXP = 6'h10,
        MODE_PERIPH = 6'h20
    } pemx_mode_type;

    typedef struct packed
    {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic write;
        logic read;
    } pemx_bus_type;

    typedef struct packed
    {
        logic eclk;
        logic eclkFall;
        logic dataEnable;
        logic pipeHi;
        logic pipeLo;
        logic clkgenTest;
        logic calibRef;
        logic lowByteStrobe;
        logic readWrite;
    } pemx_func_type;
endpackage

// >>> hw/pemx_mode_decode.sv
/*
 * pemx_mode_decode: classifies the mode into the groups the pin mux needs.
 * assumes the mode input is one-hot and steady.
 */
`timescale 1ns/1ps
`default_nettype none
module pemx_mode_decode
(
    // mode in
    input wire pemx_pkg::pemx_mode_type mode,
    // groups out
    output logic singleChip,
    output logic special,
    output logic expanded,
    output logic peripheral,
    output logic normalExp,
    output logic narrowNorm
);
    always_comb
    begin
        singleChip = (mode == pemx_pkg::MODE_NORM_SC) || (mode == pemx_pkg::MODE_SPEC_SC);
        special = (mode == pemx_pkg::MODE_SPEC_SC) || (mode == pemx_pkg::MODE_SPEC_EXP);
        peripheral = (mode == pemx_pkg::MODE_PERIPH);
        normalExp = (mode == pemx_pkg::MODE_NORM_EXP) || (mode == pemx_pkg::MODE_NORM_NARROW);
        narrowNorm = (mode == pemx_pkg::MODE_NORM_NARROW);
        expanded = normalExp || (mode == pemx_pkg::MODE_SPEC_EXP);
    end
endmodule
`default_nettype wire

// >>> hw/pemx_write_gate.sv
/*
 * pemx_write_gate: per-bit write permission for protected register bits.
 * assumes a write strobe pulse one cycle long and a synchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none
module pemx_write_gate
#(
    parameter int WIDTH = 8
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // write strobe and policy
    input wire logic write,
    input wire logic special,
    input wire logic [WIDTH-1:0] onceBits,
    input wire logic [WIDTH-1:0] anyBits,
    // permission
    output logic [WIDTH-1:0] allow
);
    logic seen;
    // seen is the only state: normal lets the first write pass, special drops it
    always_ff @(posedge mclk)
    begin
        if (reset)
            seen <= 1'b0;
        else if (write)
            seen <= 1'b1;
    end

    always_comb
    begin
        allow = anyBits | (onceBits & {WIDTH{special ? seen : !seen}});
    end
endmodule
`default_nettype wire

// >>> bench/pemx_bus_partner.sv
/*
 * pemx_bus_partner: expansion bus side of the port E pins.
 * assumes registered pin outputs from the block and one clock.
 */
`timescale 1ns/1ps
`default_nettype none
module pemx_bus_partner
(
    // clock
    input wire logic mclk,
    // pins from the block
    input wire logic [7:0] pinOut,
    input wire logic [7:0] pinOe,
    input wire logic [7:0] pinPullup,
    // resolved levels
    output logic [7:0] pinIn
);
    logic [7:0] drift = 8'h55;
    // memories only listen on port E; a floating pin wanders so no stale level passes
    always @(posedge mclk)
        drift <= ~drift;
    always_comb
        pinIn = (pinOe & pinOut) | (~pinOe & (pinPullup | drift));
endmodule
`default_nettype wire

// >>> bench/tb_pemx_pin_assign.sv
/*
 * tb_pemx_pin_assign: self-checking bench for the port E pin assignment.
 * assumes the partner model resolves the pin levels.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_pemx_pin_assign;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    pemx_pkg::pemx_mode_type mode = pemx_pkg::MODE_NORM_SC;
    logic eStretch = 1'b0;
    logic debugTagOn = 1'b0;
    pemx_pkg::pemx_bus_type bus = '0;
    // E high, data enable low, pipe hi high, low strobe high, rest low
    pemx_pkg::pemx_func_type func = 9'h122;
    logic [7:0] dir = 8'h00;
    logic [7:0] gpio = 8'h00;
    logic [7:0] rdata, pinIn, pinOut, pinOe, pinPullup, pullReg, driveReg;
    logic tagIn;
    int err_count = 0;
    int n_tests = 0;

    always #50 mclk = ~mclk;

    pemx_pin_assign pemx_pin_assign_inst (.mclk(mclk), .reset(reset), .mode(mode),
        .e_stretch_bit(eStretch), .debugTagOn(debugTagOn), .bus(bus), .rdata(rdata),
        .func(func), .port_e_direction(dir), .gpioOut(gpio), .pinIn(pinIn),
        .pinOut(pinOut), .pinOe(pinOe), .pinPullup(pinPullup), .pullup_control(pullReg),
        .reduced_drive_control(driveReg), .low_byte_tag_in(tagIn));
    pemx_bus_partner pemx_bus_partner_inst (.mclk(mclk), .pinOut(pinOut), .pinOe(pinOe),
        .pinPullup(pinPullup), .pinIn(pinIn));

    ////////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        $display("checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic restart(input pemx_pkg::pemx_mode_type m);
        reset <= 1'b1;
        mode <= m;
        eStretch <= 1'b0;
        dir <= 8'h00;
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
        @(posedge mclk);
        bus.write <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        bus <= '{addr: a, wdata: 8'h00, write: 1'b0, read: 1'b1};
        @(posedge mclk);
        bus.read <= 1'b0;
        #1;
        chk("read data", exp, rdata);
        // hand back on an edge so callers drive inputs there
        @(posedge mclk);
    endtask

    // outputs are registered, so allow the mux a few cycles to settle
    task automatic pins(input logic [7:0] oe, input logic [7:0] lvl);
        repeat (3) @(posedge mclk);
        #1;
        chk("pin enable", oe, pinOe);
        chk("pin level", lvl, pinOut & pinOe);
        @(posedge mclk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_reset_images;
        pemx_pkg::pemx_mode_type m [6] = '{pemx_pkg::MODE_NORM_SC, pemx_pkg::MODE_NORM_EXP,
            pemx_pkg::MODE_NORM_NARROW, pemx_pkg::MODE_SPEC_SC, pemx_pkg::MODE_SPEC_EXP,
            pemx_pkg::MODE_PERIPH};
        logic [7:0] img [6] = '{8'h90, 8'h00, 8'h00, 8'h2E, 8'h2C, 8'h00};
        for (int i = 0; i < 6; i++)
        begin
            restart(m[i]);
            rd(pemx_pkg::ADDR_ASSIGN, img[i]); // mode image
            rd(pemx_pkg::ADDR_PULLUP, (i == 5) ? 8'h00 : 8'h10); // pull-up
            rd(pemx_pkg::ADDR_DRIVE, 8'h00); // drive reset
            chk("pull-up register", 8'h10, pullReg); // port E resets one
        end
    endtask

    task automatic test_normal_writes;
        restart(pemx_pkg::MODE_NORM_EXP);
        wr(pemx_pkg::ADDR_ASSIGN, 8'hFF);
        rd(pemx_pkg::ADDR_ASSIGN, 8'hAF); // first write
        wr(pemx_pkg::ADDR_ASSIGN, 8'h00);
        rd(pemx_pkg::ADDR_ASSIGN, 8'hAD); // only calibration moves
        wr(pemx_pkg::ADDR_DRIVE, 8'hFF);
        wr(pemx_pkg::ADDR_DRIVE, 8'h00);
        rd(pemx_pkg::ADDR_DRIVE, 8'hF3); // drive kept once
        chk("drive register", 8'hF3, driveReg); // drive output
        wr(pemx_pkg::ADDR_PULLUP, 8'hFF);
        rd(pemx_pkg::ADDR_PULLUP, 8'hF3); // unused bits zero
        wr(pemx_pkg::ADDR_PULLUP, 8'h00);
        rd(pemx_pkg::ADDR_PULLUP, 8'h00); // rewritable
        rd(8'h0B, 8'h00);
        restart(pemx_pkg::MODE_NORM_SC);
        wr(pemx_pkg::ADDR_ASSIGN, 8'h02);
        wr(pemx_pkg::ADDR_ASSIGN, 8'h90);
        rd(pemx_pkg::ADDR_ASSIGN, 8'h00); // E disable once
    endtask

    task automatic test_special_writes;
        restart(pemx_pkg::MODE_SPEC_EXP);
        wr(pemx_pkg::ADDR_ASSIGN, 8'hFF);
        rd(pemx_pkg::ADDR_ASSIGN, 8'h2E); // first ignored except calibration bit
        wr(pemx_pkg::ADDR_ASSIGN, 8'hC3);
        rd(pemx_pkg::ADDR_ASSIGN, 8'hC3); // later accepted
        wr(pemx_pkg::ADDR_DRIVE, 8'hFF);
        rd(pemx_pkg::ADDR_DRIVE, 8'h00); // first ignored
        wr(pemx_pkg::ADDR_DRIVE, 8'hFF);
        rd(pemx_pkg::ADDR_DRIVE, 8'hF3); // later accepted
        restart(pemx_pkg::MODE_SPEC_SC);
        wr(pemx_pkg::ADDR_ASSIGN, 8'h10);
        rd(pemx_pkg::ADDR_ASSIGN, 8'h3C); // E disable any time
    endtask

    task automatic test_pins_expanded;
        restart(pemx_pkg::MODE_NORM_EXP);
        pins(8'h90, 8'h10); // data enable and E
        dir <= 8'hFF;
        gpio <= 8'hFF;
        pins(8'hFC, 8'h7C); // low pins never outputs
        dir <= 8'h00;
        gpio <= 8'h00;
        wr(pemx_pkg::ADDR_ASSIGN, 8'h2D);
        pins(8'hFC, 8'h58); // bus set
        restart(pemx_pkg::MODE_NORM_NARROW);
        wr(pemx_pkg::ADDR_ASSIGN, 8'h08);
        pins(8'h90, 8'h10); // narrow keeps pin 3 general
        restart(pemx_pkg::MODE_SPEC_EXP);
        pins(8'hFC, 8'h58); // special bus set
        debugTagOn <= 1'b1;
        for (int i = 0; i < 2; i++)
        begin
            func.lowByteStrobe <= i[0];
            repeat (3) @(posedge mclk);
            func.eclkFall <= 1'b1;
            @(posedge mclk);
            func.eclkFall <= 1'b0;
            repeat (3) @(posedge mclk);
            chk("low byte tag", {7'h00, ~i[0]}, {7'h00, tagIn}); // tag sample
        end
        debugTagOn <= 1'b0;
        wr(pemx_pkg::ADDR_ASSIGN, 8'h00);
        wr(pemx_pkg::ADDR_ASSIGN, 8'h4C);
        pins(8'hDC, 8'h18); // clock test on pin 6
    endtask

    task automatic test_pins_single;
        restart(pemx_pkg::MODE_SPEC_SC);
        pins(8'h90, 8'h10); // calibration and E
        eStretch <= 1'b1;
        pins(8'h80, 8'h00); // stretch removes E
        restart(pemx_pkg::MODE_NORM_SC);
        pins(8'h00, 8'h00); // all general
        chk("pull-up pins", 8'h8F, pinPullup); // port E pull-ups
        dir <= 8'hFF;
        repeat (3) @(posedge mclk);
        chk("pull-up pins", 8'h03, pinPullup); // inputs only
        restart(pemx_pkg::MODE_PERIPH);
        pins(8'h40, 8'h00); // test output only
        wr(pemx_pkg::ADDR_PULLUP, 8'h00);
        repeat (2) @(posedge mclk);
        chk("pull-up register", 8'h10, pullReg); // writes ignored
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        test_reset_images;
        test_normal_writes;
        test_special_writes;
        test_pins_expanded;
        test_pins_single;
        finish_test;
    end

    // hang guard: the run needs far fewer cycles than this
    initial
    begin
        repeat (20000) @(posedge mclk);
        err_count++;
        finish_test;
    end
endmodule
`default_nettype wire
